//--- src/port_adapter_consts.svh
// Purpose: constants for the dual parallel port adapter
// Assumes: included by bare name
// Notes: definitions only
`ifndef PORT_ADAPTER_CONSTS_SVH
`define PORT_ADAPTER_CONSTS_SVH
`define RSEL_SIDE_A_DATA 2'h0
`define RSEL_SIDE_A_CTRL 2'h1
`define RSEL_SIDE_B_DATA 2'h2
`define RSEL_SIDE_B_CTRL 2'h3
`define CTRL_BIT_IRQ_EN 0
`define CTRL_BIT_EDGE 1
`define CTRL_BIT_REG_PICK 2
`define CTRL_BIT_EDGE2_EN 3
`define CTRL_BIT_EDGE2 4
`define CTRL_BIT_LINE2_OUT 5
`define CTRL_BIT_FLAG2 6
`define CTRL_BIT_FLAG1 7
`define CTRL_WRITE_MASK 8'h3f
`define CS_VALID 3'h3
`define RESET_BYTE 8'h00
`endif

//--- src/port_adapter_pkg.sv
// Purpose: shared types for the dual parallel port adapter
// Assumes: nothing
// Notes: constants live in the consts header
package port_adapter_pkg;
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_READ = 2'b01,
		ACC_WRITE = 2'b10
	} access_type;
endpackage

//--- src/port_half.sv
// Purpose: one half of the adapter: output, direction and control register
// Assumes: strobes are single-cycle pulses on the system clock
// Notes: control lines arrive already synchronised
`timescale 1ns/10ps
`include "port_adapter_consts.svh"
module port_half #(
	parameter int WIDTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	// register access
	input wire logic i_data_sel,
	input wire logic i_ctrl_sel,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	// peripheral side
	input wire logic [WIDTH-1:0] i_pins,
	output logic [WIDTH-1:0] o_pins,
	output logic [WIDTH-1:0] o_pins_oe,
	input wire logic i_ctl1,
	input wire logic i_ctl2,
	output logic o_ctl2,
	output logic o_ctl2_oe,
	output logic o_irq_n
);
	logic [WIDTH-1:0] out_reg, next_out_reg;
	logic [WIDTH-1:0] dir_reg, next_dir_reg;
	logic [7:0] ctrl, next_ctrl;
	logic ctl1_q, ctl2_q, next_ctl1_q, next_ctl2_q;
	logic rise1, fall1, rise2, fall2, hit1, hit2;

	always_comb begin
		rise1 = i_ctl1 & ~ctl1_q;
		fall1 = ~i_ctl1 & ctl1_q;
		rise2 = i_ctl2 & ~ctl2_q;
		fall2 = ~i_ctl2 & ctl2_q;
		hit1 = ctrl[`CTRL_BIT_EDGE] ? rise1 : fall1; // R19
		hit2 = ~ctrl[`CTRL_BIT_LINE2_OUT] & (ctrl[`CTRL_BIT_EDGE2] ? rise2 : fall2);
		next_ctl1_q = i_ctl1;
		next_ctl2_q = i_ctl2;
		next_out_reg = out_reg;
		next_dir_reg = dir_reg;
		next_ctrl = ctrl;
		// shared address routed by the direction-access bit
		if (i_wr && i_data_sel && ctrl[`CTRL_BIT_REG_PICK]) begin // R11 R17
			next_out_reg = i_wdata[WIDTH-1:0]; // R13 R15
		end
		if (i_wr && i_data_sel && !ctrl[`CTRL_BIT_REG_PICK]) begin // R10 R17
			next_dir_reg = i_wdata[WIDTH-1:0];
		end
		// flags are read-only: writes touch only the low six bits
		if (i_wr && i_ctrl_sel) begin // R18
			next_ctrl = (ctrl & ~`CTRL_WRITE_MASK) | (i_wdata & `CTRL_WRITE_MASK);
		end
		// clear on reading the output register; a new edge wins
		if (i_rd && i_data_sel && ctrl[`CTRL_BIT_REG_PICK]) begin // R18
			next_ctrl[`CTRL_BIT_FLAG1] = 1'b0;
			next_ctrl[`CTRL_BIT_FLAG2] = 1'b0;
		end
		if (hit1) begin // R16
			next_ctrl[`CTRL_BIT_FLAG1] = 1'b1;
		end
		if (hit2) begin
			next_ctrl[`CTRL_BIT_FLAG2] = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin // R21
			out_reg <= '0;
			dir_reg <= '0;
			ctrl <= `RESET_BYTE;
			ctl1_q <= 1'b0;
			ctl2_q <= 1'b0;
		end else begin
			out_reg <= next_out_reg;
			dir_reg <= next_dir_reg;
			ctrl <= next_ctrl;
			ctl1_q <= next_ctl1_q;
			ctl2_q <= next_ctl2_q;
		end
	end

	// input lines read the pin, output lines read the stored bit
	logic [WIDTH-1:0] seen;
	always_comb begin
		seen = (i_pins & ~dir_reg) | (out_reg & dir_reg);
		if (i_ctrl_sel) begin
			o_rdata = ctrl;
		end else if (ctrl[`CTRL_BIT_REG_PICK]) begin
			o_rdata = 8'(seen);
		end else begin
			o_rdata = 8'(dir_reg);
		end
	end

	assign o_pins = out_reg; // R14
	assign o_pins_oe = dir_reg; // R12
	// set/reset output mode only; strobe modes are not provided
	assign o_ctl2 = ctrl[`CTRL_BIT_EDGE2_EN];
	assign o_ctl2_oe = ctrl[`CTRL_BIT_LINE2_OUT] & ctrl[`CTRL_BIT_EDGE2];
	// enable gates the flag at once, also for a pending one
	assign o_irq_n = ~((ctrl[`CTRL_BIT_FLAG1] & ctrl[`CTRL_BIT_IRQ_EN]) // R16 R20
		| (ctrl[`CTRL_BIT_FLAG2] & ctrl[`CTRL_BIT_EDGE2_EN] & ~ctrl[`CTRL_BIT_LINE2_OUT]));
endmodule

//--- src/port_adapter.sv
//Contract
// (R1) processor data moves over an eight-line two-way bus
// (R2) processor sets direction with read_write; device drives bus only on reads
// (R3) device ignores cycles without a valid chip-select combination
// (R4) two register-select inputs plus a control bit pick the register
// (R5) device looks like four read/write memory locations
// (R6) enable strobe times every transfer and the control logic; control-line edges are sampled on I_CLK_SYS instead
// (R7) two independent 8-bit two-way peripheral ports
// (R8) four control lines, two per side
// (R9) two halves, each with output, control and direction register
// (R10) output and direction register share one address per side
// (R11) a control bit picks output or direction register
// (R12) direction bit zero makes input, one makes output
// (R13) writes to an output register store the bus value
// (R14) stored bits drive every line marked as output
// (R15) writes to input-line bits are still accepted
// (R16) peripheral event pulls interrupt low and sets a readable flag
// (R17) direction-access bit 0 selects direction, 1 selects output register
// (R18) flags read-only, cleared by output register read or reset
// (R19) control bit one picks rising or falling edge of line 1
// (R20) control bit zero gates flag one onto interrupt, pending fires at once
// (R21) reset clears all registers: lines input, interrupts off
// Purpose: processor-facing core of a dual 8-bit parallel port
// Assumes: enable, select and pins are asynchronous to I_CLK_SYS
// Notes: an access acts once, on the falling edge of the enable strobe
`timescale 1ns/10ps
`include "port_adapter_consts.svh"
module port_adapter #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_SYS_RST,
	// processor bus
	input wire logic [2:0] I_CHIP_SELECT_LINES,
	input wire logic [1:0] I_REGISTER_SELECT_INPUTS,
	input wire logic I_READ_WRITE_SELECT,
	input wire logic I_ENABLE,
	input wire logic [7:0] I_DATA,
	output logic [7:0] O_DATA,
	output logic O_DATA_OE,
	// side a
	input wire logic [WIDTH-1:0] I_PORT_A_LINES,
	output logic [WIDTH-1:0] O_PORT_A_LINES,
	output logic [WIDTH-1:0] O_PORT_A_LINES_OE,
	input wire logic I_A_CONTROL_LINE_1,
	input wire logic I_A_CONTROL_LINE_2,
	output logic O_A_CONTROL_LINE_2,
	output logic O_A_CONTROL_LINE_2_OE,
	output logic O_IRQ_A_N,
	// side b
	input wire logic [WIDTH-1:0] I_PORT_B_LINES,
	output logic [WIDTH-1:0] O_PORT_B_LINES,
	output logic [WIDTH-1:0] O_PORT_B_LINES_OE,
	input wire logic I_B_CONTROL_LINE_1,
	input wire logic I_B_CONTROL_LINE_2,
	output logic O_B_CONTROL_LINE_2,
	output logic O_B_CONTROL_LINE_2_OE,
	output logic O_IRQ_B_N
);
	// ****************************************
	// synchronisers
	// ****************************************
	localparam int SW = 3 + 2 + 1 + 1 + 8 + 2 * WIDTH + 4;
	logic [SW-1:0] meta, sync, next_meta, next_sync;
	always_comb begin
		next_meta = {I_CHIP_SELECT_LINES, I_REGISTER_SELECT_INPUTS, I_READ_WRITE_SELECT,
			I_ENABLE, I_DATA, I_PORT_A_LINES, I_PORT_B_LINES, I_A_CONTROL_LINE_1,
			I_A_CONTROL_LINE_2, I_B_CONTROL_LINE_1, I_B_CONTROL_LINE_2};
		next_sync = meta;
	end
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			meta <= '0;
			sync <= '0;
		end else begin
			meta <= next_meta;
			sync <= next_sync;
		end
	end
	logic [2:0] cs_s;
	logic [1:0] rs_s;
	logic rw_s, en_s, ca1, ca2, cb1, cb2;
	logic [7:0] d_s;
	logic [WIDTH-1:0] pa_s, pb_s;
	assign {cs_s, rs_s, rw_s, en_s, d_s, pa_s, pb_s, ca1, ca2, cb1, cb2} = sync;

	// ****************************************
	// enable strobe timing
	// ****************************************
	logic en_q, next_en_q, en_fall;
	port_adapter_pkg::access_type acc;
	always_comb begin
		next_en_q = en_s;
		en_fall = en_q & ~en_s; // R6
		acc = port_adapter_pkg::ACC_IDLE;
		if (en_fall && cs_s == `CS_VALID) begin // R3
			acc = rw_s ? port_adapter_pkg::ACC_READ : port_adapter_pkg::ACC_WRITE; // R2
		end
	end
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			en_q <= 1'b0;
		end else begin
			en_q <= next_en_q;
		end
	end

	function automatic logic sel(input logic [1:0] rs, input logic [1:0] want);
		sel = (rs == want); // R4 R5
	endfunction

	logic rd, wr;
	assign rd = (acc == port_adapter_pkg::ACC_READ);
	assign wr = (acc == port_adapter_pkg::ACC_WRITE);
	logic [7:0] rdata_a, rdata_b;

	// ****************************************
	// the two halves
	// ****************************************
	port_half #(.WIDTH(WIDTH)) u_side_a ( // R9 R7 R8
		.i_clk(I_CLK_SYS),
		.i_rst(I_SYS_RST),
		.i_data_sel(sel(rs_s, `RSEL_SIDE_A_DATA)),
		.i_ctrl_sel(sel(rs_s, `RSEL_SIDE_A_CTRL)),
		.i_wr(wr),
		.i_rd(rd),
		.i_wdata(d_s),
		.o_rdata(rdata_a),
		.i_pins(pa_s),
		.o_pins(O_PORT_A_LINES),
		.o_pins_oe(O_PORT_A_LINES_OE),
		.i_ctl1(ca1),
		.i_ctl2(ca2),
		.o_ctl2(O_A_CONTROL_LINE_2),
		.o_ctl2_oe(O_A_CONTROL_LINE_2_OE),
		.o_irq_n(O_IRQ_A_N)
	);
	port_half #(.WIDTH(WIDTH)) u_side_b (
		.i_clk(I_CLK_SYS),
		.i_rst(I_SYS_RST),
		.i_data_sel(sel(rs_s, `RSEL_SIDE_B_DATA)),
		.i_ctrl_sel(sel(rs_s, `RSEL_SIDE_B_CTRL)),
		.i_wr(wr),
		.i_rd(rd),
		.i_wdata(d_s),
		.o_rdata(rdata_b),
		.i_pins(pb_s),
		.o_pins(O_PORT_B_LINES),
		.o_pins_oe(O_PORT_B_LINES_OE),
		.i_ctl1(cb1),
		.i_ctl2(cb2),
		.o_ctl2(O_B_CONTROL_LINE_2),
		.o_ctl2_oe(O_B_CONTROL_LINE_2_OE),
		.o_irq_n(O_IRQ_B_N)
	);

	// ****************************************
	// data bus drive
	// ****************************************
	// read data registered every clock, so the bus follows the selected register one cycle late
	logic [7:0] dout, next_dout;
	always_comb begin
		next_dout = rs_s[1] ? rdata_b : rdata_a;
	end
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			dout <= `RESET_BYTE;
		end else begin
			dout <= next_dout;
		end
	end
	assign O_DATA = dout; // R1
	assign O_DATA_OE = en_s & rw_s & (cs_s == `CS_VALID); // R2 R3
endmodule

//--- bench/port_adapter_properties.sv
// Purpose: port-level properties of the adapter
// Assumes: select lines held from one access to the next
// Notes: bound to every port_adapter
`timescale 1ns/10ps
`include "port_adapter_consts.svh"
module port_adapter_properties #(
	parameter int WIDTH = 8
) (
	input wire logic I_CLK_SYS, I_SYS_RST, I_READ_WRITE_SELECT, I_ENABLE, O_DATA_OE,
	input wire logic O_IRQ_A_N, O_IRQ_B_N,
	input wire logic [2:0] I_CHIP_SELECT_LINES,
	input wire logic [WIDTH-1:0] O_PORT_A_LINES, O_PORT_A_LINES_OE, O_PORT_B_LINES_OE
);
	// ****
	// checks
	// ****
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (I_SYS_RST);
	a_reset_idle: assert property ($fell(I_SYS_RST) |-> O_PORT_A_LINES_OE == '0
		&& O_PORT_B_LINES_OE == '0 && O_IRQ_A_N && O_IRQ_B_N) else $error("not idle");
	a_oe_read: assert property (O_DATA_OE |-> I_READ_WRITE_SELECT)
		else $error("driven on write");
	a_oe_select: assert property (O_DATA_OE |-> I_CHIP_SELECT_LINES == `CS_VALID)
		else $error("driven unselected");
	a_oe_rise: assert property ($rose(O_DATA_OE) |-> I_ENABLE)
		else $error("driven without enable");
	a_oe_drop: assert property ($fell(I_ENABLE) |-> ##[1:4] !O_DATA_OE)
		else $error("bus held");
	a_regs_quiet: assert property ((!I_ENABLE) [*6] |=> $stable(O_PORT_A_LINES)
		&& $stable(O_PORT_A_LINES_OE) && $stable(O_PORT_B_LINES_OE)) else $error("reg moved");
	a_cs_ignore: assert property ((I_CHIP_SELECT_LINES != `CS_VALID) [*8] |=>
		$stable(O_PORT_A_LINES_OE) && $stable(O_PORT_B_LINES_OE)) else $error("unselected acted");
	a_irq_a_clear: assert property ($rose(O_IRQ_A_N) |-> !I_ENABLE)
		else $error("irq a early");
	a_irq_b_clear: assert property ($rose(O_IRQ_B_N) |-> !I_ENABLE)
		else $error("irq b early");
	c_read: cover property ($rose(O_DATA_OE));
	c_irq_a: cover property ($fell(O_IRQ_A_N));
	c_irq_b: cover property ($fell(O_IRQ_B_N));
endmodule
bind port_adapter port_adapter_properties #(.WIDTH(WIDTH)) chk (.*);

//--- bench/cpu_model.sv
// Purpose: processor bus master
// Assumes: moves at the falling edge
// Notes: undriven data shows inverted
`timescale 1ns/10ps
module cpu_model (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output logic [2:0] o_cs,
	output logic [1:0] o_rs,
	output logic o_rw,
	output logic o_en,
	output logic [7:0] o_wdata
);
	// ****
	// bus cycle
	// ****
	initial begin
		o_cs = 3'h0;
		o_rs = 2'h0;
		o_rw = 1'b1;
		o_en = 1'b0;
		o_wdata = 8'h00;
	end
	task automatic xfer(input logic [2:0] c, input logic [1:0] r, input logic w,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge i_clk);
		o_cs = c;
		o_rs = r;
		o_rw = w;
		o_wdata = w ? ~o_wdata : d;
		o_en = 1'b1;
		repeat (6) @(negedge i_clk);
		q = i_rdata;
		o_en = 1'b0;
		repeat (6) @(negedge i_clk);
	endtask
endmodule

//--- bench/port_adapter_tb.sv
// Purpose: self-checking bench
// Assumes: map and timing as handed over
// Notes: pins resolve from both enables
`timescale 1ns/10ps
`include "port_adapter_consts.svh"
module port_adapter_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] cs;
	logic [1:0] rs;
	logic [1:0] c1 = 2'h0;
	logic [1:0] c2 = 2'h0;
	logic rw, en, oe, c2a, c2ae, c2b, c2be, irqa, irqb;
	logic [7:0] wd, rd, oa, ob, oea, oeb, q;
	logic [7:0] ea = 8'h00;
	logic [7:0] eb = 8'h00;
	int err_count = 0;
	int checks = 0;
	int orr[2], ddr[2], cr[2], fl[2], f2[2];
	// ****
	// harness
	// ****
	initial forever #5 clk = ~clk;
	// a bus the device does not drive shows the inverse, so a missing enable is caught
	cpu_model cpu (.i_clk(clk), .i_rdata(oe ? rd : ~rd), .o_cs(cs), .o_rs(rs), .o_rw(rw),
		.o_en(en),
		.o_wdata(wd));
	port_adapter DUT (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CHIP_SELECT_LINES(cs),
		.I_REGISTER_SELECT_INPUTS(rs), .I_READ_WRITE_SELECT(rw), .I_ENABLE(en), .I_DATA(wd),
		.O_DATA(rd), .O_DATA_OE(oe), .I_PORT_A_LINES(oa & oea | ea & ~oea), .O_PORT_A_LINES(oa),
		.O_PORT_A_LINES_OE(oea), .I_A_CONTROL_LINE_1(c1[0]), .I_A_CONTROL_LINE_2(c2[0]),
		.O_A_CONTROL_LINE_2(c2a), .O_A_CONTROL_LINE_2_OE(c2ae), .O_IRQ_A_N(irqa),
		.I_PORT_B_LINES(ob & oeb | eb & ~oeb), .O_PORT_B_LINES(ob), .O_PORT_B_LINES_OE(oeb),
		.I_B_CONTROL_LINE_1(c1[1]), .I_B_CONTROL_LINE_2(c2[1]), .O_B_CONTROL_LINE_2(c2b),
		.O_B_CONTROL_LINE_2_OE(c2be), .O_IRQ_B_N(irqb));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report;
		if (err_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// line 2 only raises a request while it is an input
	function automatic logic irq_exp(input int s);
		irq_exp = !(fl[s] && cr[s] % 2 || f2[s] && cr[s] & 8 && !(cr[s] & 32));
	endfunction
	// expectation is taken before the cycle, since a data read clears flags
	task automatic acc(input int r, input int w, input int d, input logic [2:0] c = `CS_VALID);
		int s;
		logic [7:0] e;
		s = r / 2;
		e = 8'(r % 2 ? cr[s] | fl[s] << 7 | f2[s] << 6 : cr[s] & 4 ?
			orr[s] & ddr[s] | (s ? eb : ea) & ~ddr[s] : ddr[s]);
		cpu.xfer(c, 2'(r), w[0], 8'(d), q);
		if (c == `CS_VALID && w[0]) begin
			chk("rd", e, q);
			if (r % 2 == 0 && cr[s] & 4) begin
				fl[s] = 0;
				f2[s] = 0;
			end
		end
		if (c == `CS_VALID && !w[0]) begin
			if (r % 2) cr[s] = d & `CTRL_WRITE_MASK;
			else if (cr[s] & 4) orr[s] = d & 255;
			else ddr[s] = d & 255;
		end
		chk("dir a", 8'(ddr[0]), oea);
		chk("dir b", 8'(ddr[1]), oeb);
		chk("out a", 8'(orr[0]), oa);
		chk("out b", 8'(orr[1]), ob);
		chk("irq a", 8'(irq_exp(0)), 8'(irqa));
		chk("irq b", 8'(irq_exp(1)), 8'(irqb));
		chk("ctl2 a", 8'(cr[0] >> 3 & 1), 8'(c2a));
		chk("ctl2 b", 8'(cr[1] >> 3 & 1), 8'(c2b));
		chk("ctl2 oe a", 8'(cr[0] >> 5 & cr[0] >> 4 & 1), 8'(c2ae));
		chk("ctl2 oe b", 8'(cr[1] >> 5 & cr[1] >> 4 & 1), 8'(c2be));
	endtask
	// only the edge picked by the control register may set a flag
	task automatic pulse(input int s, input int n, input logic v);
		@(negedge clk);
		if (n == 1) begin
			c1[s] = v;
		end else begin
			c2[s] = v;
		end
		repeat (8) @(negedge clk);
		if (n == 1 && (cr[s] >> 1 & 1) == v) begin
			fl[s] = 1;
		end
		if (n == 2 && (cr[s] >> 4 & 1) == v && !(cr[s] & 32)) begin
			f2[s] = 1;
		end
	endtask
	// ****
	// tests
	// ****
	initial begin
		void'($urandom(32'h863dba87));
		repeat (5) @(negedge clk);
		rst = 1'b0;
		for (int r = 0; r < 4; r++) acc(r, 1, 0);
		for (int s = 0; s < 2; s++) begin
			acc(2 * s + 1, 0, 8'h00);
			acc(2 * s, 0, 8'h0f << s);
			acc(2 * s + 1, 0, 8'hc4);
			acc(2 * s, 0, 8'ha5);
		end
		for (int i = 0; i < 40; i++) begin
			ea = 8'($urandom);
			eb = 8'($urandom);
			acc($urandom % 4, $urandom % 2, $urandom);
		end
		for (int c = 0; c < 8; c++) acc($urandom % 4, 0, $urandom, 3'(c));
		for (int s = 0; s < 2; s++) begin
			acc(2 * s + 1, 0, 8'h06);
			pulse(s, 1, 1'b1);
			acc(2 * s + 1, 1, 0);
			acc(2 * s + 1, 0, 8'h07);
			acc(2 * s, 1, 0);
			acc(2 * s + 1, 0, 8'h05);
			pulse(s, 1, 1'b0);
			acc(2 * s + 1, 1, 0);
			acc(2 * s, 1, 0);
			pulse(s, 1, 1'b1);
			acc(2 * s + 1, 1, 0);
			acc(2 * s + 1, 0, 8'h1c);
			pulse(s, 2, 1'b1);
			acc(2 * s + 1, 1, 0);
			acc(2 * s, 1, 0);
			acc(2 * s + 1, 0, 8'h3c);
		end
		final_report();
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		final_report();
	end
endmodule
